/* design/i2cms_baud.v */
// Purpose: Baud rate generator that paces master bus phases.
// Assumes: Reload value written by software; tick is a one-cycle pulse.
// Notes: Restarts from reload whenever the engine is idle.
module i2cms_baud #(
   parameter WIDTH = 16
) (
   input wire i_mclk,
   input wire i_nrst,
   input wire i_run,
   input wire [WIDTH-1:0] i_reload,
   output wire o_tick
);
   reg [WIDTH-1:0] cnt_q;
   // ***********************************************
   // Down counter.
   // ***********************************************
   // Count reloads from baud_reload at each tick.
   always @(posedge i_mclk) begin
      if (!i_nrst || !i_run || cnt_q == {WIDTH{1'b0}}) begin
         cnt_q <= i_reload;
      end else begin
         cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
   // Tick when the count runs out while running.
   assign o_tick = i_run && (cnt_q == {WIDTH{1'b0}});
endmodule // i2cms_baud

/* design/i2cms_ctrl.v */
// Purpose: Control, master sequencer and slave receiver of a two-wire bus controller.
// Assumes: Pins are open-drain; outputs drive low when the enable is high.
// Notes: Master transmit of a byte starts on a write to tx_holding while the master holds the clock low.
//
// Decided for this implementation: strobed register access and the register addresses.
`include "i2cms_regs.vh"
// What this block does
// - mod_on enables the block and hands both pins to it.
// - idle_stop halts the block while the device is idle.
// - clock_release one frees the clock; zero holds it low while the own slave is addressed; resets to one.
// - Stretch on: free writes; cleared at slave transmit start and receive end.
// - Stretch off: only ones written; cleared at slave transmit start.
// - stretch_enable turns software and receive stretching on or off.
// - accept_all_addresses acknowledges every address.
// - ten_bit_addr_mode picks 10-bit or 7-bit own address.
// - General call received with enable set raises an interrupt pulse.
// - Master acknowledge drives ack_value on the data line.
// - ack_sequence_go sends the acknowledge and clears itself after.
// - receive_go receives a byte; cleared after the eighth bit.
// - stop_go makes a stop; cleared when done.
// - restart_go makes a repeated start; cleared when done.
// - start_go makes a start; cleared when done.
// - Full shift byte moves to rx_buffer with an interrupt pulse.
// - Control read/write except bit 14, which reads zero; status low six bits read-only.
// - rx_shift has no software path; software writes tx_holding.
// - Baud generator reloads from baud_reload.
module i2cms_ctrl (
   input wire i_mclk,
   input wire i_nrst,
   input wire i_idle,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   input wire i_scl,
   output wire o_scl,
   output wire o_scl_oe,
   input wire i_sda,
   output wire o_sda,
   output wire o_sda_oe,
   output wire o_pins_owned,
   output wire o_irq_pulse
);
   localparam ST_IDLE = 4'h0;
   localparam ST_START = 4'h1;
   localparam ST_RESTART = 4'h2;
   localparam ST_STOP = 4'h3;
   localparam ST_RX = 4'h4;
   localparam ST_ACK = 4'h5;
   localparam ST_TX = 4'h6;
   reg [15:0] con_q;
   reg [15:0] stat_q;
   reg [7:0] rxbuf_q;
   reg [7:0] tx_q;
   reg [9:0] own_q;
   reg [15:0] baud_q;
   reg [7:0] sh_q;
   reg [3:0] st_q;
   reg [1:0] ph_q;
   reg [3:0] bit_q;
   reg scl_drv_q;
   reg sda_drv_q;
   reg irq_q;
   reg [1:0] scl_s_q;
   reg [1:0] sda_s_q;
   reg [1:0] idle_s_q;
   reg scl_d1_q;
   reg sda_d1_q;
   reg sl_act_q;
   reg sl_addr_q;
   reg sl_tx_q;
   reg sl_ack_q;
   reg sl_match_q;
   reg [3:0] sl_bit_q;
   reg [7:0] sl_sh_q;
   wire run;
   wire tick;
   wire scl_in;
   wire sda_in;
   wire scl_rise;
   wire scl_fall;
   wire start_det;
   wire stop_det;
   wire wr_con;
   wire hit7;
   wire hit10;
   wire gcall;
   wire addr_hit;
   wire rx_done_m;
   wire rx_done_s;
   wire [15:0] st_hw;
   // ***********************************************
   // Pin synchronisers.
   // ***********************************************
   // Pins and the idle level pass two flops before use.
   always @(posedge i_mclk) begin
      if (!i_nrst) begin
         scl_s_q <= 2'h3;
         sda_s_q <= 2'h3;
         idle_s_q <= 2'h0;
         scl_d1_q <= 1'b1;
         sda_d1_q <= 1'b1;
      end else begin
         scl_s_q <= {scl_s_q[0], i_scl};
         sda_s_q <= {sda_s_q[0], i_sda};
         idle_s_q <= {idle_s_q[0], i_idle};
         scl_d1_q <= scl_s_q[1];
         sda_d1_q <= sda_s_q[1];
      end
   end
   assign scl_in = scl_s_q[1];
   assign sda_in = sda_s_q[1];
   assign scl_rise = scl_in && !scl_d1_q;
   assign scl_fall = !scl_in && scl_d1_q;
   assign start_det = scl_in && scl_d1_q && !sda_in && sda_d1_q;
   assign stop_det = scl_in && scl_d1_q && sda_in && !sda_d1_q;
   // Block runs when enabled and not stopped by idle.
   assign run = con_q[`I2CMS_CON_MOD_ON] && !(con_q[`I2CMS_CON_IDLE_STOP] && idle_s_q[1]);
   assign wr_con = i_wr && i_addr == `I2CMS_OFF_CONTROL;
   i2cms_baud #(
      .WIDTH(16)
   ) u_baud (
      .i_mclk(i_mclk),
      .i_nrst(i_nrst),
      .i_run(run && st_q != ST_IDLE),
      .i_reload(baud_q),
      .o_tick(tick)
   );
   // ***********************************************
   // Slave address matching.
   // ***********************************************
   // Seven-bit or ten-bit first-byte compare.
   assign hit7 = !con_q[`I2CMS_CON_TEN_BIT] && sl_sh_q[7:1] == own_q[6:0];
   assign hit10 = con_q[`I2CMS_CON_TEN_BIT] && sl_sh_q[7:1] == {5'h1e, own_q[9:8]};
   assign gcall = con_q[`I2CMS_CON_GC_EN] && sl_sh_q == `I2CMS_GCALL_ADDR;
   assign addr_hit = hit7 || hit10 || gcall || con_q[`I2CMS_CON_ACCEPT_ALL];
   assign rx_done_m = st_q == ST_RX && ph_q == 2'h3 && tick && bit_q == 4'h7;
   assign rx_done_s = sl_act_q && !sl_addr_q && !sl_tx_q && scl_rise && sl_bit_q == 4'h7;
   // ***********************************************
   // Slave engine.
   // ***********************************************
   // Tracks frames, matches address, shifts data and acknowledges.
   always @(posedge i_mclk) begin
      if (!i_nrst || !run || start_det || stop_det) begin
         sl_act_q <= run && start_det;
         sl_addr_q <= 1'b1;
         sl_tx_q <= 1'b0;
         sl_ack_q <= 1'b0;
         sl_match_q <= 1'b0;
         sl_bit_q <= 4'h0;
         sl_sh_q <= 8'h00;
      end else if (sl_act_q) begin
         if (scl_rise && sl_bit_q < 4'h8) begin
            sl_sh_q <= {sl_sh_q[6:0], sda_in};
            sl_bit_q <= sl_bit_q + 4'h1;
         end else if (scl_fall && sl_bit_q == 4'h8 && !sl_ack_q) begin
            sl_ack_q <= sl_addr_q ? addr_hit : sl_match_q && !sl_tx_q;
            if (sl_addr_q) begin
               sl_match_q <= addr_hit;
               sl_tx_q <= addr_hit && sl_sh_q[0] && !gcall;
            end
         end else if (scl_fall && sl_bit_q == 4'h8) begin
            sl_ack_q <= 1'b0;
            sl_addr_q <= 1'b0;
            sl_bit_q <= 4'h0;
         end else if (scl_fall && sl_bit_q == 4'h9) begin
            sl_bit_q <= 4'h0;
         end
         if (scl_fall && sl_tx_q && !sl_addr_q && sl_bit_q < 4'h8 && sl_bit_q != 4'h0) begin
            sl_sh_q <= {sl_sh_q[6:0], 1'b0};
         end
      end
   end
   // ***********************************************
   // Master sequencer.
   // ***********************************************
   // Four baud phases per bit drive start, restart, stop, receive and ack.
   always @(posedge i_mclk) begin
      if (!i_nrst || !run) begin
         st_q <= ST_IDLE;
         ph_q <= 2'h0;
         bit_q <= 4'h0;
         scl_drv_q <= 1'b0;
         sda_drv_q <= 1'b0;
         sh_q <= 8'h00;
      end else begin
         case (st_q)
            ST_IDLE: begin
               ph_q <= 2'h0;
               bit_q <= 4'h0;
               // One request taken at a time, lowest bit first.
               if (con_q[`I2CMS_CON_START_GO]) begin
                  st_q <= ST_START;
               end else if (con_q[`I2CMS_CON_RESTART_GO]) begin
                  st_q <= ST_RESTART;
               end else if (con_q[`I2CMS_CON_STOP_GO]) begin
                  st_q <= ST_STOP;
               end else if (con_q[`I2CMS_CON_RX_GO]) begin
                  st_q <= ST_RX;
               end else if (con_q[`I2CMS_CON_ACK_GO]) begin
                  st_q <= ST_ACK;
               end else if (stat_q[`I2CMS_STAT_TXFULL] && scl_drv_q) begin
                  st_q <= ST_TX;
                  sh_q <= tx_q;
               end
            end
            default: begin
               if (tick) begin
                  ph_q <= ph_q + 2'h1;
                  case (st_q)
                     // Data falls while clock is high.
                     ST_START: begin
                        sda_drv_q <= ph_q >= 2'h1;
                        scl_drv_q <= ph_q >= 2'h2;
                        if (ph_q == 2'h3) st_q <= ST_IDLE;
                     end
                     // Release data, raise clock, then fall data.
                     ST_RESTART: begin
                        sda_drv_q <= ph_q == 2'h3;
                        scl_drv_q <= ph_q == 2'h0;
                        if (ph_q == 2'h3) st_q <= ST_IDLE;
                     end
                     // Data rises while clock is high.
                     ST_STOP: begin
                        sda_drv_q <= ph_q != 2'h3;
                        scl_drv_q <= ph_q == 2'h0;
                        if (ph_q == 2'h3) st_q <= ST_IDLE;
                     end
                     // Sample eight bits on clock high.
                     ST_RX: begin
                        sda_drv_q <= 1'b0;
                        scl_drv_q <= ph_q == 2'h0 || ph_q == 2'h3;
                        if (ph_q == 2'h2) sh_q <= {sh_q[6:0], sda_in};
                        if (ph_q == 2'h3) bit_q <= bit_q + 4'h1;
                        if (rx_done_m) st_q <= ST_IDLE;
                     end
                     // Send eight bits then release for the ack slot.
                     ST_TX: begin
                        sda_drv_q <= bit_q < 4'h8 && !sh_q[7];
                        scl_drv_q <= ph_q == 2'h0 || ph_q == 2'h3;
                        if (ph_q == 2'h3) begin
                           bit_q <= bit_q + 4'h1;
                           sh_q <= {sh_q[6:0], 1'b0};
                           if (bit_q == 4'h8) st_q <= ST_IDLE;
                        end
                     end
                     // Drive ack_value for one bit time.
                     default: begin
                        sda_drv_q <= !con_q[`I2CMS_CON_ACK_VAL];
                        scl_drv_q <= ph_q == 2'h0 || ph_q == 2'h3;
                        if (ph_q == 2'h3) st_q <= ST_IDLE;
                     end
                  endcase
               end
            end
         endcase
      end
   end
   // ***********************************************
   // Control register.
   // ***********************************************
   // Software writes; hardware clears go bits and clock_release.
   always @(posedge i_mclk) begin
      if (!i_nrst) begin
         con_q <= `I2CMS_CON_RESET;
      end else begin
         if (wr_con) begin
            con_q <= i_wdata & `I2CMS_CON_WMASK;
            // Without stretching only a one may be written.
            if (!con_q[`I2CMS_CON_STRETCH_EN]) begin
               con_q[`I2CMS_CON_CLK_REL] <= con_q[`I2CMS_CON_CLK_REL] | i_wdata[`I2CMS_CON_CLK_REL];
            end
         end
         if (st_q != ST_IDLE && tick && ph_q == 2'h3) begin
            case (st_q)
               ST_START: con_q[`I2CMS_CON_START_GO] <= 1'b0;
               ST_RESTART: con_q[`I2CMS_CON_RESTART_GO] <= 1'b0;
               ST_STOP: con_q[`I2CMS_CON_STOP_GO] <= 1'b0;
               ST_ACK: con_q[`I2CMS_CON_ACK_GO] <= 1'b0;
               default: con_q[`I2CMS_CON_MOD_ON] <= con_q[`I2CMS_CON_MOD_ON];
            endcase
         end
         if (rx_done_m) begin
            con_q[`I2CMS_CON_RX_GO] <= 1'b0;
         end
         // Hold clock at slave transmit start, and at receive end when stretching.
         if ((sl_addr_q && sl_ack_q && scl_fall && sl_tx_q) ||
             (rx_done_s && sl_match_q && con_q[`I2CMS_CON_STRETCH_EN])) begin
            con_q[`I2CMS_CON_CLK_REL] <= 1'b0;
         end
      end
   end
   // ***********************************************
   // Data registers and status.
   // ***********************************************
   // Completed bytes move to rx_buffer with an interrupt pulse.
   always @(posedge i_mclk) begin
      if (!i_nrst) begin
         stat_q <= 16'h0000;
         rxbuf_q <= 8'h00;
         tx_q <= 8'h00;
         own_q <= 10'h000;
         baud_q <= `I2CMS_BAUD_RESET;
         irq_q <= 1'b0;
      end else begin
         irq_q <= rx_done_m || (rx_done_s && sl_match_q) ||
                  (sl_addr_q && scl_fall && sl_bit_q == 4'h8 && !sl_ack_q && gcall);
         if (i_wr && i_addr == `I2CMS_OFF_STATUS) begin
            stat_q[15:6] <= i_wdata[15:6];
         end
         if (i_wr && i_addr == `I2CMS_OFF_TXHOLD) begin
            tx_q <= i_wdata[7:0];
         end
         if (i_wr && i_addr == `I2CMS_OFF_ADDR) begin
            own_q <= i_wdata[9:0];
         end
         if (i_wr && i_addr == `I2CMS_OFF_BAUD) begin
            baud_q <= i_wdata;
         end
         // Buffer full set wins over the read that empties it.
         if (rx_done_m) begin
            rxbuf_q <= sh_q;
         end else if (rx_done_s && sl_match_q) begin
            rxbuf_q <= {sl_sh_q[6:0], sda_in};
         end
         stat_q[5:0] <= st_hw[5:0];
      end
   end
   assign st_hw[`I2CMS_STAT_RXFULL] = rx_done_m || (rx_done_s && sl_match_q) ||
      (stat_q[`I2CMS_STAT_RXFULL] && !(i_rd && i_addr == `I2CMS_OFF_RXBUF));
   assign st_hw[`I2CMS_STAT_TXFULL] = (i_wr && i_addr == `I2CMS_OFF_TXHOLD) ||
      (stat_q[`I2CMS_STAT_TXFULL] && !(st_q == ST_TX));
   assign st_hw[`I2CMS_STAT_RW_READ] = sl_tx_q;
   assign st_hw[`I2CMS_STAT_GCALL] = sl_act_q && gcall && !sl_addr_q;
   assign st_hw[`I2CMS_STAT_ADDR_MATCH] = sl_match_q;
   assign st_hw[`I2CMS_STAT_BUSY] = st_q != ST_IDLE || sl_act_q;
   assign st_hw[15:6] = 10'h000;
   // ***********************************************
   // Read port.
   // ***********************************************
   // Read data stand the cycle after the strobe; rx_shift has no address.
   always @(posedge i_mclk) begin
      if (!i_nrst) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         case (i_addr)
            `I2CMS_OFF_CONTROL: o_rdata <= con_q;
            `I2CMS_OFF_STATUS: o_rdata <= stat_q;
            `I2CMS_OFF_RXBUF: o_rdata <= {8'h00, rxbuf_q};
            `I2CMS_OFF_TXHOLD: o_rdata <= {8'h00, tx_q};
            `I2CMS_OFF_ADDR: o_rdata <= {6'h00, own_q};
            `I2CMS_OFF_BAUD: o_rdata <= baud_q;
            default: o_rdata <= 16'h0000;
         endcase
      end else begin
         o_rdata <= 16'h0000;
      end
   end
   // ***********************************************
   // Pin drive.
   // ***********************************************
   // Pins owned only while enabled; clock held when clock_release is zero while the own slave is addressed.
   assign o_pins_owned = con_q[`I2CMS_CON_MOD_ON];
   assign o_scl = 1'b0;
   assign o_sda = 1'b0;
   assign o_scl_oe = run && (scl_drv_q || (sl_match_q && !con_q[`I2CMS_CON_CLK_REL] && !scl_in));
   assign o_sda_oe = run && (sda_drv_q || sl_ack_q ||
      (sl_tx_q && !sl_addr_q && sl_bit_q < 4'h8 && !sl_sh_q[7]));
   assign o_irq_pulse = irq_q;
endmodule // i2cms_ctrl

/* design/i2cms_regs.vh */
// Purpose: Register offsets, field positions, reset values and timing counts of the two-wire bus controller.
// Assumes: Register bus with word indices; 16-bit registers in the low bits of the data word.
// Notes: Included by the control design file only; definitions only.
`ifndef I2CMS_REGS_VH
`define I2CMS_REGS_VH
// ***********************************************
// Register offsets.
// ***********************************************
`define I2CMS_OFF_CONTROL 4'h0
`define I2CMS_OFF_STATUS 4'h1
`define I2CMS_OFF_RXBUF 4'h2
`define I2CMS_OFF_TXHOLD 4'h3
`define I2CMS_OFF_ADDR 4'h4
`define I2CMS_OFF_BAUD 4'h5
// ***********************************************
// Control fields.
// ***********************************************
`define I2CMS_CON_MOD_ON 15
`define I2CMS_CON_IDLE_STOP 13
`define I2CMS_CON_CLK_REL 12
`define I2CMS_CON_ACCEPT_ALL 11
`define I2CMS_CON_TEN_BIT 10
`define I2CMS_CON_GC_EN 7
`define I2CMS_CON_STRETCH_EN 6
`define I2CMS_CON_ACK_VAL 5
`define I2CMS_CON_ACK_GO 4
`define I2CMS_CON_RX_GO 3
`define I2CMS_CON_STOP_GO 2
`define I2CMS_CON_RESTART_GO 1
`define I2CMS_CON_START_GO 0
`define I2CMS_CON_WMASK 16'hbfff
`define I2CMS_CON_RESET 16'h1000
// ***********************************************
// Status fields (low six bits read-only).
// ***********************************************
`define I2CMS_STAT_RO_MASK 16'h003f
`define I2CMS_STAT_RXFULL 0
`define I2CMS_STAT_TXFULL 1
`define I2CMS_STAT_RW_READ 2
`define I2CMS_STAT_GCALL 3
`define I2CMS_STAT_ADDR_MATCH 4
`define I2CMS_STAT_BUSY 5
`define I2CMS_BAUD_RESET 16'h0010
`define I2CMS_GCALL_ADDR 8'h00
`endif

/* verification/i2c_master_slave_control_tb.sv */
// Purpose: Self-checking bench for the two-wire bus controller.
// Assumes: Word-indexed register port; read data one cycle after the strobe.
// Notes: Register cases run from a table; sequences, idle and reset are hand-written.
module i2c_master_slave_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_mclk = 1'b0, i_nrst = 1'b0, i_idle = 1'b0, i_wr = 1'b0, i_rd = 1'b0, arm = 1'b0, seen_sda = 1'b0;
   logic [3:0] i_addr = 4'h0;
   logic [15:0] i_wdata = 16'h0000, o_rdata, v;
   logic o_scl, o_scl_oe, o_sda, o_sda_oe, o_pins_owned, o_irq_pulse, p_oe;
   int error_cnt = 0, n_checks = 0, irq_cnt = 0;
   // Rows: index, write data, compare mask, expected read.
   logic [51:0] rows [9] = '{{4'h0, 16'h2ec0, 16'hffff, 16'h3ec0},
      {4'h0, 16'h1000, 16'hffff, 16'h1000}, {4'h0, 16'h0000, 16'hffff, 16'h1000},
      {4'h0, 16'h5040, 16'hffff, 16'h1040}, {4'h0, 16'h0040, 16'hffff, 16'h0040},
      {4'h1, 16'hffff, 16'hffff, 16'hffc0}, {4'h4, 16'h0155, 16'h03ff, 16'h0155},
      {4'h5, 16'h0003, 16'h00ff, 16'h0003}, {4'h9, 16'hffff, 16'hffff, 16'h0000}};
   wire scl_w = !o_scl_oe;
   wire sda_w = !(o_sda_oe || p_oe);
   i2cms_ctrl dut_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_idle(i_idle), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(scl_w), .o_scl(o_scl), .o_scl_oe(o_scl_oe),
      .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_pins_owned(o_pins_owned), .o_irq_pulse(o_irq_pulse));
   i2cms_peer peer_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(scl_w), .i_arm(arm), .i_byte(8'ha5),
      .o_sda_oe(p_oe));
   // Clock of 4 ns and the pulse and drive monitors.
   initial begin
      forever #2 i_mclk = !i_mclk;
   end
   always @(posedge i_mclk) begin
      if (o_irq_pulse === 1'b1) irq_cnt <= irq_cnt + 1;
      if (o_sda_oe === 1'b1) seen_sda <= 1'b1;
   end
   // ***********************************************
   // Tasks.
   // ***********************************************
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, g);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_mclk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge i_mclk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_mclk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask
   // Polls control until the given request bits have been cleared by the hardware.
   task automatic waitclr(input logic [15:0] m, input string n);
      logic [15:0] r;
      r = m;
      for (int i = 0; i < 400 && (r & m) != 16'h0000; i++) rd(4'h0, r);
      chk(n, 16'h0000, r & m);
   endtask
   task automatic summarize;
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ***********************************************
   // Main sequence.
   // ***********************************************
   initial begin
      repeat (12) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rd(4'h0, v);
      chk("control reset", 16'h1000, v);
      rd(4'h5, v);
      chk("baud reset", 16'h0010, v);
      chk("owned reset", 1'b0, o_pins_owned);
      for (int k = 0; k < 9; k++) begin
         wr(rows[k][51:48], rows[k][47:32]);
         rd(rows[k][51:48], v);
         chk("register row", rows[k][15:0], v & rows[k][31:16]);
      end
      wr(4'h0, 16'h8001);
      waitclr(16'h0001, "start clear");
      chk("owned on", 1'b1, o_pins_owned);
      chk("start data low", 1'b1, o_sda_oe);
      @(posedge i_mclk) arm <= 1'b1;
      @(posedge i_mclk) arm <= 1'b0;
      wr(4'h0, 16'h8008);
      waitclr(16'h0008, "receive clear");
      repeat (2) @(posedge i_mclk);
      chk("irq count", 16'h0001, irq_cnt[15:0]);
      rd(4'h1, v);
      chk("rx full", 16'h0001, v & 16'h0001);
      rd(4'h2, v);
      chk("rx byte", 16'h00a5, v & 16'h00ff);
      rd(4'h1, v);
      chk("rx full read", 16'h0000, v & 16'h0001);
      seen_sda = 1'b0;
      wr(4'h0, 16'h8030);
      waitclr(16'h0010, "nack clear");
      chk("nack released", 1'b0, seen_sda);
      seen_sda = 1'b0;
      wr(4'h0, 16'h8010);
      waitclr(16'h0010, "ack clear");
      chk("ack driven", 1'b1, seen_sda);
      wr(4'h0, 16'h8002);
      waitclr(16'h0002, "restart clear");
      chk("restart data low", 1'b1, o_sda_oe);
      wr(4'h0, 16'h8004);
      waitclr(16'h0004, "stop clear");
      chk("stop free", 2'b00, {o_scl_oe, o_sda_oe});
      @(posedge i_mclk) i_idle <= 1'b1;
      wr(4'h0, 16'hb001);
      repeat (100) @(posedge i_mclk);
      rd(4'h0, v);
      chk("idle halt", 16'h0001, v & 16'h0001);
      @(posedge i_mclk) i_idle <= 1'b0;
      waitclr(16'h0001, "idle resume");
      // The master sends the own seven-bit address; the own slave must flag a match with the read bit clear.
      wr(4'h3, 16'h00aa);
      repeat (200) @(posedge i_mclk);
      rd(4'h1, v);
      chk("address match", 16'h0010, v & 16'h0014);
      wr(4'h0, 16'h8004);
      waitclr(16'h0004, "stop clear");
      wr(4'h0, 16'h0000);
      repeat (3) @(posedge i_mclk);
      chk("owned off", 1'b0, o_pins_owned);
      i_nrst <= 1'b0;
      repeat (3) @(posedge i_mclk);
      i_nrst <= 1'b1;
      rd(4'h0, v);
      chk("control rereset", 16'h1000, v);
      summarize;
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      #200000;
      error_cnt++;
      summarize;
   end
endmodule // i2c_master_slave_control_tb

/* verification/i2cms_ctrl_props.sv */
// Purpose: Concurrent checks on the ports of the two-wire bus controller.
// Assumes: One clock domain; synchronous active-low reset.
// Notes: Attached by bind at the foot of this file.
module i2cms_ctrl_props (
   input wire i_mclk,
   input wire i_nrst,
   input wire i_idle,
   input wire [3:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [15:0] o_rdata,
   input wire i_scl,
   input wire o_scl,
   input wire o_scl_oe,
   input wire i_sda,
   input wire o_sda,
   input wire o_sda_oe,
   input wire o_pins_owned,
   input wire o_irq_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_nrst);
   // ***********************************************
   // Bus steps.
   // ***********************************************
   sequence s_ctl_rd;
      i_rd && i_addr == 4'h0;
   endsequence
   sequence s_ctl_wr;
      i_wr && i_addr == 4'h0;
   endsequence
   // Read data shows only in the cycle after a read, gaps read zero, ownership follows the enable.
   a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data seen outside the read answer cycle");
   a_ctl_gap: assert property (s_ctl_rd |=> o_rdata[14] == 1'b0)
      else $error("control bit 14 read back as one");
   a_unmapped_zero: assert property (i_rd && i_addr > 4'h5 |=> o_rdata == 16'h0000)
      else $error("unmapped index returned data");
   a_owned_follow: assert property (s_ctl_wr |-> ##2 o_pins_owned == $past(i_wdata[15], 2))
      else $error("pin ownership does not follow the enable bit");
   a_off_release: assert property (!o_pins_owned && !$past(o_pins_owned) |-> !o_scl_oe && !o_sda_oe)
      else $error("pins driven while the block is off");
   a_open_drain: assert property (o_scl == 1'b0 && o_sda == 1'b0)
      else $error("pin output value is not low");
   a_irq_single: assert property (o_irq_pulse |=> !o_irq_pulse)
      else $error("interrupt pulse longer than one cycle");
   a_off_no_irq: assert property (!o_pins_owned && !$past(o_pins_owned) |-> !o_irq_pulse)
      else $error("interrupt raised while the block is off");
endmodule // i2cms_ctrl_props

bind i2cms_ctrl i2cms_ctrl_props props_u (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_idle(i_idle), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_scl(i_scl), .o_scl(o_scl),
   .o_scl_oe(o_scl_oe), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .o_pins_owned(o_pins_owned),
   .o_irq_pulse(o_irq_pulse));

/* verification/i2cms_peer.sv */
// Purpose: Bus slave that shifts one byte onto the data line for a master receive.
// Assumes: Open-drain lines with pull-ups; the master drives the clock.
// Notes: Data changes only after a falling clock, so it is steady while the clock is high.
module i2cms_peer (
   input wire i_mclk,
   input wire i_nrst,
   input wire i_scl,
   input wire i_arm,
   input wire [7:0] i_byte,
   output logic o_sda_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sh_q;
   logic [2:0] cnt_q;
   logic armed_q;
   logic scl_q;
   // Loads the byte on arm, moves to the next bit, msb first, at each clock fall; frees the line after eight.
   always @(posedge i_mclk) begin
      scl_q <= i_scl;
      if (!i_nrst) begin
         armed_q <= 1'b0;
      end else if (i_arm) begin
         armed_q <= 1'b1;
         sh_q <= i_byte;
         cnt_q <= 3'h0;
      end else if (armed_q && scl_q && !i_scl) begin
         sh_q <= {sh_q[6:0], 1'b1};
         cnt_q <= cnt_q + 3'h1;
         armed_q <= (cnt_q != 3'h7);
      end
   end
   // A zero bit pulls the line low; a one or a freed line leaves it to the pull-up.
   assign o_sda_oe = armed_q && !sh_q[7];
endmodule // i2cms_peer
